// [design/jdp_map.svh]
// widths, codes and timing constants of the debug test port
`ifndef JDP_MAP_SVH
`define JDP_MAP_SVH

`define JDP_IR_W 4
`define JDP_ID_W 32
`define JDP_WORD_W 8
`define JDP_IR_CAPTURE 4'h1
`define JDP_INS_IDCODE 4'h2
`define JDP_INS_STATUS 4'h8
`define JDP_INS_CTRL 4'h9
`define JDP_INS_BYPASS 4'hF
`define JDP_SYS_PERIOD_NS 25
`define JDP_EVT_PULSE_NS 100
`define JDP_EVT_PULSE_CYC ((`JDP_EVT_PULSE_NS + `JDP_SYS_PERIOD_NS - 1) / `JDP_SYS_PERIOD_NS)
`define JDP_EVT_CNT_W 3

`endif

// [design/jdp_pkg.sv]
// types of the debug test port
`include "jdp_map.svh"
package jdp_pkg;
	typedef enum logic [15:0] {
		ST_RESET = 16'h0001,
		ST_IDLE = 16'h0002,
		ST_SELDR = 16'h0004,
		ST_CAPDR = 16'h0008,
		ST_SHDR = 16'h0010,
		ST_EX1DR = 16'h0020,
		ST_PSDR = 16'h0040,
		ST_EX2DR = 16'h0080,
		ST_UPDR = 16'h0100,
		ST_SELIR = 16'h0200,
		ST_CAPIR = 16'h0400,
		ST_SHIR = 16'h0800,
		ST_EX1IR = 16'h1000,
		ST_PSIR = 16'h2000,
		ST_EX2IR = 16'h4000,
		ST_UPIR = 16'h8000
	} jdp_tap_type;

	typedef struct packed {
		logic valid;
		logic [`JDP_WORD_W-1:0] word;
	} jdp_ctrl_type;
endpackage : jdp_pkg

// [design/jdp_sync.sv]
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module jdp_sync (
	input wire logic clk,
	input wire logic rstN,
	input wire logic d,
	output logic q
);
	logic meta_reg;

	always_ff @(posedge clk) begin
		if (!rstN) begin
			meta_reg <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : jdp_sync
`default_nettype wire

// [design/jdp_port.sv]
// debug test port: tap controller on the test clock, crossings to the system clock
`timescale 1ns/1ps
`default_nettype none
`include "jdp_map.svh"
// Summary of operation
// [RULE1] mode select is sampled on each rising test clock edge to step the tap
// [RULE2] serial data input is captured on each rising test clock edge
// [RULE3] data output driven only in shift-ir or shift-dr, else high impedance
// [RULE4] data output changes on the falling test clock edge
// [RULE5] low test reset puts the tap controller into its reset state
// [RULE6] far end asserts test reset with device reset; device reset alone spares the port
// [RULE7] each recognised debug event gives one low pulse on the event output; events arriving during a running pulse merge into it
// [RULE8] test clock, possibly gated, is the only clock of the test logic
// [RULE9] standard sixteen-state tap; instruction selects the data path
module jdp_port #(
	parameter logic [`JDP_ID_W-1:0] IDCODE_VALUE = 32'h0000_0001 // arbitrary value
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	output logic tdo,
	output logic tdoOe_n,
	output logic debugEventOut_n,
	input wire logic dbgEvent,
	input wire logic [`JDP_WORD_W-1:0] statusWord,
	output jdp_pkg::jdp_ctrl_type ctrlOut
);
	import jdp_pkg::*;

	localparam int unsigned PAD_W = `JDP_ID_W - `JDP_WORD_W;
	localparam logic [`JDP_EVT_CNT_W-1:0] EVT_CYC = `JDP_EVT_CNT_W'(`JDP_EVT_PULSE_CYC);

	jdp_tap_type tapState;
	jdp_tap_type tapNext;
	logic [`JDP_IR_W-1:0] irShift_reg;
	logic [`JDP_IR_W-1:0] ir_reg;
	logic [`JDP_ID_W-1:0] drShift_reg;
	logic [`JDP_WORD_W-1:0] ctrlHold_reg;
	logic ctrlTgl_reg;
	logic reqMeta_reg;
	logic reqTck_reg;
	logic ackTck_reg;
	logic [`JDP_WORD_W-1:0] statusTck_reg;

	// tap next state, stepped by mode select
	always_comb begin
		case (tapState)
			ST_RESET: tapNext = tms ? ST_RESET : ST_IDLE;
			ST_IDLE: tapNext = tms ? ST_SELDR : ST_IDLE;
			ST_SELDR: tapNext = tms ? ST_SELIR : ST_CAPDR;
			ST_CAPDR: tapNext = tms ? ST_EX1DR : ST_SHDR;
			ST_SHDR: tapNext = tms ? ST_EX1DR : ST_SHDR;
			ST_EX1DR: tapNext = tms ? ST_UPDR : ST_PSDR;
			ST_PSDR: tapNext = tms ? ST_EX2DR : ST_PSDR;
			ST_EX2DR: tapNext = tms ? ST_UPDR : ST_SHDR;
			ST_UPDR: tapNext = tms ? ST_SELDR : ST_IDLE;
			ST_SELIR: tapNext = tms ? ST_RESET : ST_CAPIR;
			ST_CAPIR: tapNext = tms ? ST_EX1IR : ST_SHIR;
			ST_SHIR: tapNext = tms ? ST_EX1IR : ST_SHIR;
			ST_EX1IR: tapNext = tms ? ST_UPIR : ST_PSIR;
			ST_PSIR: tapNext = tms ? ST_EX2IR : ST_PSIR;
			ST_EX2IR: tapNext = tms ? ST_UPIR : ST_SHIR;
			ST_UPIR: tapNext = tms ? ST_SELDR : ST_IDLE;
			default: tapNext = ST_RESET;
		endcase
	end

	// decoding of the loaded instruction; unknown codes fall back to bypass
	wire selId = (ir_reg == `JDP_INS_IDCODE);
	wire selStat = (ir_reg == `JDP_INS_STATUS);
	wire selCtrl = (ir_reg == `JDP_INS_CTRL);
	wire selByp = !(selId || selStat || selCtrl);
	wire shiftIr = (tapState == ST_SHIR);
	wire shiftDr = (tapState == ST_SHDR);
	wire [`JDP_WORD_W-1:0] capWord = selStat ? statusTck_reg : ctrlHold_reg;
	wire [`JDP_ID_W-1:0] drCapture = selId ? IDCODE_VALUE
		: selByp ? '0 : {{PAD_W{1'b0}}, capWord};
	wire [`JDP_ID_W-1:0] drShifted = selId ? {tdi, drShift_reg[`JDP_ID_W-1:1]}
		: selByp ? {{(`JDP_ID_W-1){1'b0}}, tdi}
		: {{PAD_W{1'b0}}, tdi, drShift_reg[`JDP_WORD_W-1:1]};
	wire tdoSrc = shiftIr ? irShift_reg[0] : drShift_reg[0];

	// all tap logic on the test clock; device reset leaves it running, see [RULE6] [RULE8]
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tapState <= ST_RESET; // see [RULE5]
		end else begin
			tapState <= tapNext; // see [RULE1] [RULE9]
		end
	end

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			irShift_reg <= `JDP_IR_CAPTURE;
			ir_reg <= `JDP_INS_IDCODE; // see [RULE5]
		end else begin
			if (tapState == ST_CAPIR) begin
				irShift_reg <= `JDP_IR_CAPTURE;
			end else if (shiftIr) begin
				irShift_reg <= {tdi, irShift_reg[`JDP_IR_W-1:1]}; // see [RULE2]
			end
			if (tapState == ST_RESET) begin
				ir_reg <= `JDP_INS_IDCODE;
			end else if (tapState == ST_UPIR) begin
				ir_reg <= irShift_reg; // see [RULE9]
			end
		end
	end

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			drShift_reg <= '0;
		end else if (tapState == ST_CAPDR) begin
			drShift_reg <= drCapture;
		end else if (shiftDr) begin
			drShift_reg <= drShifted; // see [RULE2] [RULE9]
		end
	end

	// control word is held until the next update; a second update before the
	// system side has taken the first can be seen torn, so hosts space them out
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ctrlHold_reg <= '0;
			ctrlTgl_reg <= 1'b0;
		end else if (tapState == ST_UPDR && selCtrl) begin
			ctrlHold_reg <= drShift_reg[`JDP_WORD_W-1:0];
			ctrlTgl_reg <= ~ctrlTgl_reg;
		end
	end

	// status word arrives by request/acknowledge handshake
	logic statusReq_reg;
	logic [`JDP_WORD_W-1:0] statusHold_reg;
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			reqMeta_reg <= 1'b0;
			reqTck_reg <= 1'b0;
			ackTck_reg <= 1'b0;
			statusTck_reg <= '0;
		end else begin
			reqMeta_reg <= statusReq_reg;
			reqTck_reg <= reqMeta_reg;
			if (reqTck_reg != ackTck_reg) begin
				statusTck_reg <= statusHold_reg;
				ackTck_reg <= reqTck_reg;
			end
		end
	end

	// output stage on the falling edge so the far end samples a settled bit
	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tdo <= 1'b0;
			tdoOe_n <= 1'b1; // see [RULE3] [RULE5]
		end else begin
			tdo <= tdoSrc; // see [RULE4]
			tdoOe_n <= ~(shiftIr || shiftDr); // see [RULE3]
		end
	end

	// system clock side
	logic ackSys;
	logic ctrlTglSys;
	logic ctrlSeen_reg;
	logic [`JDP_EVT_CNT_W-1:0] evtCnt_reg;

	jdp_sync uAckSync (
		.clk(clk_sys),
		.rstN(rst_n),
		.d(ackTck_reg),
		.q(ackSys)
	);

	// not cleared by device reset, so a word delivered before it is never replayed
	jdp_sync uCtrlSync (
		.clk(clk_sys),
		.rstN(1'b1),
		.d(ctrlTgl_reg),
		.q(ctrlTglSys)
	);

	wire statusFree = (statusReq_reg == ackSys);
	wire ctrlArrived = (ctrlTglSys != ctrlSeen_reg);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			statusReq_reg <= 1'b0;
			statusHold_reg <= '0;
		end else if (statusFree) begin
			statusHold_reg <= statusWord;
			statusReq_reg <= ~statusReq_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrlSeen_reg <= ctrlTglSys;
			ctrlOut <= '0;
		end else begin
			ctrlSeen_reg <= ctrlTglSys;
			ctrlOut.valid <= ctrlArrived;
			if (ctrlArrived) begin
				ctrlOut.word <= ctrlHold_reg;
			end
		end
	end

	// events arriving while a pulse is running merge into it
	wire evtStart = dbgEvent && (evtCnt_reg == '0);
	wire [`JDP_EVT_CNT_W-1:0] evtCnt_next = evtStart ? EVT_CYC
		: (evtCnt_reg != '0) ? evtCnt_reg - 1'b1 : '0;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			evtCnt_reg <= '0;
			debugEventOut_n <= 1'b1;
		end else begin
			evtCnt_reg <= evtCnt_next;
			debugEventOut_n <= (evtCnt_next == '0); // see [RULE7]
		end
	end

	a_tms_advance: assert property (@(posedge tck) disable iff (!trst_n) // see [RULE1]
		(tapState == ST_IDLE && tms) |=> (tapState == ST_SELDR))
		else $error("tap did not step on mode select");

	a_tdi_capture: assert property (@(posedge tck) disable iff (!trst_n) // see [RULE2]
		(shiftDr && selByp) |=> (drShift_reg[0] == $past(tdi)))
		else $error("data input not captured");

	a_tdo_drive_window: assert property (@(posedge tck) disable iff (!trst_n) // see [RULE3]
		(!tdoOe_n) == (shiftIr || shiftDr))
		else $error("data output driven outside shift states");

	a_tdo_ir_value: assert property (@(posedge tck) disable iff (!trst_n) // see [RULE4]
		(shiftIr && !tdoOe_n) |-> (tdo == irShift_reg[0]))
		else $error("data output not updated on falling edge");

	a_trst_holds_tap: assert property (@(posedge tck) // see [RULE5]
		!trst_n |-> (tapState == ST_RESET && tdoOe_n && ir_reg == `JDP_INS_IDCODE))
		else $error("test reset did not reset tap");

	a_five_ones_reset: assert property (@(posedge tck) disable iff (!trst_n) // see [RULE9]
		tms [*5] |=> (tapState == ST_RESET))
		else $error("five ones did not reach reset");

	a_ir_update: assert property (@(posedge tck) disable iff (!trst_n) // see [RULE9]
		(tapState == ST_UPIR) |=> (ir_reg == $past(irShift_reg)))
		else $error("instruction not loaded on update");

	a_event_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE7]
		evtStart |=> !debugEventOut_n [*4] ##1 debugEventOut_n)
		else $error("event pulse wrong length");

	a_ctrl_single: assert property (@(posedge clk_sys) disable iff (!rst_n) // control valid lasts a single system clock cycle
		ctrlOut.valid |=> !ctrlOut.valid)
		else $error("control valid longer than one cycle");
endmodule : jdp_port
`default_nettype wire

// [verification/jdp_jtag_host.sv]
// behavioural test controller on the far side of the debug test port
`timescale 1ns/1ps
`default_nettype none
module jdp_jtag_host (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdoLine,
	input wire logic tdoOe_n
);
	logic oeBad;
	logic oeNow;
	// clock stands low between frames, idle inputs rest at their pull-up level
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		oeBad = 1'b0;
		oeNow = 1'b1;
	end
	// lines change after the falling edge, so they are settled at the rising one
	task tick(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#80 tck = 1'b1;
		o = tdoLine;
		oeNow = tdoOe_n;
		#80 tck = 1'b0;
	endtask : tick
	// from idle through one shift path and back to idle, lsb first
	task scan(input logic isIr, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic o;
		dout = '0;
		oeBad = 1'b0;
		// one low tick first, so a frame may also start from the reset state
		tick(1'b0, 1'b1, o);
		tick(1'b1, 1'b1, o);
		if (isIr) tick(1'b1, 1'b1, o);
		tick(1'b0, 1'b1, o);
		tick(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o);
			dout[i] = o;
			oeBad |= oeNow;
		end
		tick(1'b1, 1'b1, o);
		oeBad |= !oeNow;
		tick(1'b0, 1'b1, o);
	endtask : scan
endmodule : jdp_jtag_host
`default_nettype wire

// [verification/tb.sv]
// self-checking bench of the debug test port
`timescale 1ns/1ps
`default_nettype none
`include "jdp_map.svh"
module tb;
	import jdp_pkg::*;
	localparam logic [31:0] ID_VALUE = 32'h1234_5679; // arbitrary value
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	// lowered just after time zero, so the asynchronous reset sees a real edge
	logic trst_n = 1'b1;
	logic dbgEvent = 1'b0;
	logic [7:0] statusWord = 8'h00;
	logic tck, tms, tdi, tdo, tdoOe_n, debugEventOut_n;
	jdp_ctrl_type ctrlOut;
	logic [31:0] dout, rnd;
	logic [7:0] prevWord;
	logic [7:0] expQ[$];
	int num_errors = 0;
	int checked = 0;
	int n;
	// a released line shows the inverse so a stale value never passes
	wire tdoLine = tdoOe_n ? ~tdo : tdo;
	always #12.5 clk_sys = ~clk_sys;
	jdp_port #(.IDCODE_VALUE(ID_VALUE)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck),
		.tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdoOe_n(tdoOe_n),
		.debugEventOut_n(debugEventOut_n), .dbgEvent(dbgEvent), .statusWord(statusWord),
		.ctrlOut(ctrlOut));
	jdp_jtag_host host_u (.tck(tck), .tms(tms), .tdi(tdi), .tdoLine(tdoLine), .tdoOe_n(tdoOe_n));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task results;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	// each delivered control word takes the oldest note
	always @(negedge clk_sys) begin
		if (ctrlOut.valid === 1'b1) begin
			if (expQ.size() == 0) check(1, 0);
			else check(ctrlOut.word, expQ.pop_front());
		end
	end
	initial begin
		#1000000;
		num_errors++;
		results();
	end
	initial begin
		rnd = 32'hB80E9BD7;
		#2 trst_n = 1'b0;
		repeat (10) @(negedge clk_sys);
		check(tdoOe_n, 1);
		rst_n = 1'b1;
		trst_n = 1'b1;
		host_u.scan(0, 32, 0, dout);
		check(dout, ID_VALUE);
		check(host_u.oeBad, 0);
		$display("identity test done");
		for (int k = 0; k < 3; k++) begin
			rnd = lfsr(rnd);
			host_u.scan(1, 4, `JDP_INS_CTRL, dout);
			check(dout[3:0], `JDP_IR_CAPTURE);
			expQ.push_back(rnd[7:0]);
			host_u.scan(0, 8, rnd, dout);
			if (k > 0) check(dout[7:0], prevWord);
			prevWord = rnd[7:0];
		end
		rnd = lfsr(rnd);
		@(negedge clk_sys) statusWord = rnd[7:0];
		repeat (20) @(negedge clk_sys);
		host_u.scan(1, 4, `JDP_INS_STATUS, dout);
		host_u.scan(0, 8, 0, dout);
		check(dout[7:0], rnd[7:0]);
		$display("control and status test done");
		for (int j = 0; j < 2; j++) begin
			host_u.scan(1, 4, (j > 0) ? 4'h5 : `JDP_INS_BYPASS, dout);
			host_u.scan(0, 2, 32'h1, dout);
			check(dout[1:0], 2'b10);
		end
		// five rising edges with mode select high reach reset and reload the identity path
		repeat (5) host_u.tick(1'b1, 1'b1, dout[0]);
		host_u.scan(0, 32, 0, dout);
		check(dout, ID_VALUE);
		host_u.scan(1, 4, `JDP_INS_IDCODE, dout);
		@(negedge clk_sys) rst_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		check({debugEventOut_n, ctrlOut}, {1'b1, 9'h000});
		rst_n = 1'b1;
		host_u.scan(0, 32, 0, dout);
		check(dout, ID_VALUE);
		host_u.scan(1, 4, `JDP_INS_BYPASS, dout);
		// three updates left the toggle odd, so clearing it hands over a zero word
		expQ.push_back(8'h00);
		@(negedge clk_sys) trst_n = 1'b0;
		host_u.tick(1'b0, 1'b1, dout[0]);
		@(negedge clk_sys) check(tdoOe_n, 1);
		trst_n = 1'b1;
		host_u.scan(0, 32, 0, dout);
		check(dout, ID_VALUE);
		$display("reset test done");
		n = 0;
		@(negedge clk_sys) dbgEvent = 1'b1;
		@(negedge clk_sys) dbgEvent = 1'b0;
		if (debugEventOut_n === 1'b0) n++;
		@(negedge clk_sys) dbgEvent = 1'b1;
		for (int c = 0; c < 10; c++) begin
			if (debugEventOut_n === 1'b0) n++;
			@(negedge clk_sys) dbgEvent = 1'b0;
		end
		check(n, `JDP_EVT_PULSE_CYC);
		check(32'(expQ.size()), 0);
		$display("debug event test done");
		results();
	end
endmodule : tb
`default_nettype wire
